// ### core/host_bus_config_strap_decoder.sv
// Configuration strap decoder with Wishbone registers and column data output.
// Notes on behaviour
// [RQ1] Strap low direct, high indirect addressing.
// [RQ2] Two-bit strap selects host bus style.
// [RQ3] Ratio strap sets column shift clock period.
// [RQ4] Straps resampled continuously, no reset needed.
// [RQ5] Straps tied firmly to supply or ground.
// [RQ6] External clock used: crystal input held low.
// [RQ7] Crystal used: external clock input held low.
// [RQ8] External clock used: crystal output left open.
// [RQ9] Column nibble valid at each shift falling edge.
// [RQ10] Indirect decodes address LSB only; direct all.
// [RQ11] Reserved codes, enable-clocked direct flagged invalid.
`timescale 1ns/10ps
module host_bus_config_strap_decoder (
   // System.
   input  wire logic                                   clk_i,
   input  wire logic                                   rst_i,
   // Wishbone slave.
   input  wire logic                                   wb_cyc_i,
   input  wire logic                                   wb_stb_i,
   input  wire logic                                   wb_we_i,
   input  wire logic         [strap_pkg::WB_ADR_W-1:0] wb_adr_i,
   input  wire logic         [strap_pkg::WB_SEL_W-1:0] wb_sel_i,
   input  wire logic         [strap_pkg::WB_DAT_W-1:0] wb_dat_i,
   output logic              [strap_pkg::WB_DAT_W-1:0] wb_dat_o,
   output logic                                        wb_ack_o,
   // Straps and host address pins.
   input  wire logic          [strap_pkg::STRAP_W-1:0] config_straps_i,
   input  wire logic      [strap_pkg::HOST_ADDR_W-2:0] host_addr_upper_i,
   input  wire logic                                   host_addr_lsb_i,
   // Decoded configuration.
   output logic                                        addressing_indirect_o,
   output strap_pkg::bus_style_t                       bus_style_o,
   output strap_pkg::shift_ratio_t                     shift_ratio_o,
   output logic                                        config_valid_o,
   output logic           [strap_pkg::HOST_ADDR_W-1:0] host_reg_index_o,
   // Panel column interface.
   output logic                                        column_shift_clock_o,
   output logic              [strap_pkg::NIBBLE_W-1:0] column_data_out_o
);
   logic [strap_pkg::STRAP_W-1:0]     straps_s;
   logic [strap_pkg::HOST_ADDR_W-1:0] addr_s;

   // Decoded strap state.
   logic                              indirect_reg;
   logic                              indirect_next;
   strap_pkg::bus_style_t             style_reg;
   strap_pkg::bus_style_t             style_next;
   strap_pkg::shift_ratio_t           ratio_reg;
   strap_pkg::shift_ratio_t           ratio_next;
   logic                              style_res_reg;
   logic                              style_res_next;
   logic                              ratio_res_reg;
   logic                              ratio_res_next;
   logic                              unsupp_reg;
   logic                              unsupp_next;
   logic                              valid_reg;
   logic                              valid_next;
   logic [strap_pkg::HOST_ADDR_W-1:0] index_reg;
   logic [strap_pkg::HOST_ADDR_W-1:0] index_next;

   // Bus and transfer state.
   logic                              ack_reg;
   logic                              ack_next;
   logic [strap_pkg::WB_DAT_W-1:0]    dat_reg;
   logic [strap_pkg::WB_DAT_W-1:0]    dat_next;
   logic [strap_pkg::WB_DAT_W-1:0]    ctrl_reg;
   logic [strap_pkg::WB_DAT_W-1:0]    ctrl_next;
   logic [strap_pkg::WB_DAT_W-1:0]    data_reg;
   logic [strap_pkg::WB_DAT_W-1:0]    data_next;
   logic                              pending_reg;
   logic                              pending_next;
   logic                              load_reg;
   logic                              load_next;
   logic                              hit;
   logic                              accept;
   logic [strap_pkg::WB_DAT_W-1:0]    status;

   column_link_if link ();

   // Pins are asynchronous to clk_i and pass two flip-flops first.
   strap_sync #(
      .WIDTH (strap_pkg::STRAP_W)
   ) u_strap_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (config_straps_i),
      .q_o   (straps_s)
   );

   strap_sync #(
      .WIDTH (strap_pkg::HOST_ADDR_W)
   ) u_addr_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({host_addr_upper_i, host_addr_lsb_i}),
      .q_o   (addr_s)
   );

   column_shifter u_shifter (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .link  (link.shifter)
   );

   // Straps are decoded every cycle, so a changed strap takes effect without a reset.
   always_comb begin
      indirect_next  = straps_s[strap_pkg::ADDR_MODE_BIT]; // [RQ1] [RQ4]
      style_next     = strap_pkg::bus_style_t'(straps_s[strap_pkg::STYLE_LSB +: 2]); // [RQ2]
      ratio_next     = strap_pkg::shift_ratio_t'(straps_s[strap_pkg::RATIO_LSB +: 2]); // [RQ3]
      style_res_next = (style_next == strap_pkg::STYLE_RESERVED); // [RQ11]
      ratio_res_next = (ratio_next == strap_pkg::RATIO_RESERVED); // [RQ11]
      unsupp_next    = (style_next == strap_pkg::STYLE_ENABLE_CLOCKED) && !indirect_next; // [RQ11]
      valid_next     = !(style_res_next || ratio_res_next || unsupp_next); // [RQ11]
      if (indirect_next) begin
         index_next = {{(strap_pkg::HOST_ADDR_W-1){1'b0}}, addr_s[0]}; // [RQ10] [RQ1]
      end else begin
         index_next = addr_s; // [RQ10] [RQ1]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         indirect_reg  <= 1'b0;
         style_reg     <= strap_pkg::STYLE_GENERIC;
         ratio_reg     <= strap_pkg::RATIO_4;
         style_res_reg <= 1'b0;
         ratio_res_reg <= 1'b0;
         unsupp_reg    <= 1'b0;
         valid_reg     <= 1'b0;
         index_reg     <= '0;
      end else begin
         indirect_reg  <= indirect_next;
         style_reg     <= style_next;
         ratio_reg     <= ratio_next;
         style_res_reg <= style_res_next;
         ratio_res_reg <= ratio_res_next;
         unsupp_reg    <= unsupp_next;
         valid_reg     <= valid_next;
         index_reg     <= index_next;
      end
   end

   always_comb begin
      status = '0;
      status[strap_pkg::ST_RATIO_LSB +: 2] = ratio_reg;
      status[strap_pkg::ST_STYLE_LSB +: 2] = style_reg;
      status[strap_pkg::ST_INDIRECT]       = indirect_reg;
      status[strap_pkg::ST_VALID]          = valid_reg;
      status[strap_pkg::ST_BUSY]           = link.busy;
      status[strap_pkg::ST_PENDING]        = pending_reg;
      status[strap_pkg::ST_STYLE_RES]      = style_res_reg;
      status[strap_pkg::ST_RATIO_RES]      = ratio_res_reg;
      status[strap_pkg::ST_UNSUPP]         = unsupp_reg;
   end

   // Invalid straps hold the word back rather than shift at an undefined rate.
   assign hit    = wb_cyc_i && wb_stb_i && !ack_reg;
   assign accept = pending_reg && ctrl_reg[strap_pkg::CTRL_ENABLE] && valid_reg // [RQ11]
                   && !link.busy && !load_reg;

   always_comb begin
      ack_next     = hit;
      dat_next     = '0;
      ctrl_next    = ctrl_reg;
      data_next    = data_reg;
      pending_next = pending_reg;
      load_next    = accept;
      if (accept) begin
         pending_next = 1'b0;
      end
      if (hit && !wb_we_i) begin
         unique case (wb_adr_i)
            strap_pkg::REG_STATUS:     dat_next = status;
            strap_pkg::REG_CTRL:       dat_next = ctrl_reg;
            strap_pkg::REG_DATA:       dat_next = data_reg;
            strap_pkg::REG_HOST_INDEX: dat_next = 32'(index_reg);
            default:                   dat_next = '0;
         endcase
      end
      if (hit && wb_we_i) begin
         for (int b = 0; b < strap_pkg::WB_SEL_W; b++) begin
            if (wb_sel_i[b] && wb_adr_i == strap_pkg::REG_CTRL) begin
               ctrl_next[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
            if (wb_sel_i[b] && wb_adr_i == strap_pkg::REG_DATA) begin
               data_next[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
         end
         // A new word wins over the hand-off clearing the pending flag.
         if (wb_adr_i == strap_pkg::REG_DATA) begin
            pending_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg     <= 1'b0;
         dat_reg     <= '0;
         ctrl_reg    <= strap_pkg::CTRL_RESET;
         data_reg    <= strap_pkg::DATA_RESET;
         pending_reg <= 1'b0;
         load_reg    <= 1'b0;
      end else begin
         ack_reg     <= ack_next;
         dat_reg     <= dat_next;
         ctrl_reg    <= ctrl_next;
         data_reg    <= data_next;
         pending_reg <= pending_next;
         load_reg    <= load_next;
      end
   end

   assign link.load             = load_reg;
   assign link.word             = data_reg;
   assign link.ratio            = ratio_reg; // [RQ3]
   assign wb_ack_o              = ack_reg;
   assign wb_dat_o              = dat_reg;
   assign addressing_indirect_o = indirect_reg;
   assign bus_style_o           = style_reg;
   assign shift_ratio_o         = ratio_reg;
   assign config_valid_o        = valid_reg;
   assign host_reg_index_o      = index_reg;
   assign column_shift_clock_o  = link.sclk;
   assign column_data_out_o     = link.nibble;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ADDR_MODE: assert property ( // [RQ1]
      !$past(rst_i) |-> addressing_indirect_o == $past(straps_s[strap_pkg::ADDR_MODE_BIT]))
      else $error("Addressing mode does not follow the strap.");

   AST_BUS_STYLE: assert property ( // [RQ2]
      !$past(rst_i) |-> bus_style_o == $past(straps_s[strap_pkg::STYLE_LSB +: 2]))
      else $error("Bus style does not follow the strap.");

   AST_STRAP_FOLLOW: assert property ( // [RQ4]
      $stable(config_straps_i)[*3] ##0 !($past(rst_i, 1) || $past(rst_i, 2) || $past(rst_i, 3))
      |-> addressing_indirect_o == config_straps_i[strap_pkg::ADDR_MODE_BIT]
          && shift_ratio_o == config_straps_i[strap_pkg::RATIO_LSB +: 2])
      else $error("Strap change not applied within three cycles.");

   AST_ADDR_DECODE: assert property ( // [RQ10]
      !$past(rst_i) |-> host_reg_index_o == (addressing_indirect_o
         ? {15'h0000, $past(addr_s[0])} : $past(addr_s)))
      else $error("Host address decode ignores the addressing mode.");

   AST_VALID_CODES: assert property ( // [RQ11]
      config_valid_o |-> bus_style_o != strap_pkg::STYLE_RESERVED
         && shift_ratio_o != strap_pkg::RATIO_RESERVED
         && !(bus_style_o == strap_pkg::STYLE_ENABLE_CLOCKED && !addressing_indirect_o))
      else $error("Invalid strap combination reported as valid.");

   AST_RATIO_FOLLOW: assert property ( // [RQ3]
      !$past(rst_i)
      |-> shift_ratio_o == $past(straps_s[strap_pkg::RATIO_LSB +: 2]))
      else $error("Ratio ignores strap.");

   // Every invalid code raises its own flag and clears valid.
   AST_STYLE_RES: assert property ( // [RQ11]
      bus_style_o == strap_pkg::STYLE_RESERVED
      |-> style_res_reg && !config_valid_o)
      else $error("Style flag missing.");

   AST_RATIO_RES: assert property ( // [RQ11]
      shift_ratio_o == strap_pkg::RATIO_RESERVED
      |-> ratio_res_reg && !config_valid_o)
      else $error("Ratio flag missing.");

   AST_UNSUPP: assert property ( // [RQ11]
      bus_style_o == strap_pkg::STYLE_ENABLE_CLOCKED
      && !addressing_indirect_o
      |-> unsupp_reg && !config_valid_o)
      else $error("Unsupported flag missing.");

   // An undefined rate would feed the drivers garbage, so the word waits.
   AST_HOLD_INVALID: assert property ( // [RQ11]
      !config_valid_o
      |=> !link.load)
      else $error("Invalid word handed off.");

   // A floating upper pin must not leak into the index.
   AST_INDEX_UPPER: assert property ( // [RQ10]
      addressing_indirect_o
      |-> host_reg_index_o[strap_pkg::HOST_ADDR_W-1:1] == '0)
      else $error("Upper index bits set.");

   AST_LOAD_IDLE: assert property ( // [RQ9]
      link.load
      |-> !link.busy)
      else $error("Load while busy.");

   // A stopped clock rests low, so no stray capture edge occurs.
   AST_CLOCK_IDLE: assert property ( // [RQ9]
      !link.busy
      |-> !column_shift_clock_o)
      else $error("Clock runs while idle.");
endmodule

// ### core/strap_pkg.sv
// Shared constants and types for the configuration strap decoder.
package strap_pkg;

   // Strap layout.
   localparam int STRAP_W       = 5;
   localparam int ADDR_MODE_BIT = 4;
   localparam int STYLE_LSB     = 2;
   localparam int RATIO_LSB     = 0;
   localparam int CODE_W        = 2;

   // Host address pins.
   localparam int HOST_ADDR_W     = 16;
   localparam int DIRECT_ADDR_W   = 16;
   localparam int INDIRECT_ADDR_W = 1;

   // Column data path.
   localparam int WORD_W   = 32;
   localparam int NIBBLE_W = 4;
   localparam int NIBBLES  = WORD_W / NIBBLE_W;
   localparam int CNT_W    = 4;

   // Column shift clock period in input clocks, and its half.
   localparam int DIV_4  = 4;
   localparam int DIV_8  = 8;
   localparam int DIV_16 = 16;
   localparam logic [CNT_W-1:0] HALF_4  = CNT_W'(DIV_4 / 2);
   localparam logic [CNT_W-1:0] HALF_8  = CNT_W'(DIV_8 / 2);
   localparam logic [CNT_W-1:0] HALF_16 = CNT_W'(DIV_16 / 2);

   typedef enum logic [CODE_W-1:0] {
      STYLE_GENERIC        = 2'h0,
      STYLE_RESERVED       = 2'h1,
      STYLE_ENABLE_CLOCKED = 2'h2,
      STYLE_STROBE_ACK     = 2'h3
   } bus_style_t;

   typedef enum logic [CODE_W-1:0] {
      RATIO_4        = 2'h0,
      RATIO_8        = 2'h1,
      RATIO_16       = 2'h2,
      RATIO_RESERVED = 2'h3
   } shift_ratio_t;

   // Wishbone register map.
   localparam int             WB_ADR_W       = 8;
   localparam int             WB_DAT_W       = 32;
   localparam int             WB_SEL_W       = 4;
   localparam logic [7:0]     REG_STATUS     = 8'h00;
   localparam logic [7:0]     REG_CTRL       = 8'h04;
   localparam logic [7:0]     REG_DATA       = 8'h08;
   localparam logic [7:0]     REG_HOST_INDEX = 8'h0c;
   localparam logic [31:0]    CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0]    DATA_RESET     = 32'h0000_0000;
   localparam int             CTRL_ENABLE    = 0;

   // Status bit positions.
   localparam int ST_RATIO_LSB = 0;
   localparam int ST_STYLE_LSB = 2;
   localparam int ST_INDIRECT  = 4;
   localparam int ST_VALID     = 5;
   localparam int ST_BUSY      = 6;
   localparam int ST_PENDING   = 7;
   localparam int ST_STYLE_RES = 8;
   localparam int ST_RATIO_RES = 9;
   localparam int ST_UNSUPP    = 10;

endpackage

// ### core/column_link_if.sv
// Link between the strap decoder and the column shifter.
`timescale 1ns/10ps
interface column_link_if;
   logic                                          load;
   logic                  [strap_pkg::WORD_W-1:0] word;
   strap_pkg::shift_ratio_t                       ratio;
   logic                                          busy;
   logic                                          sclk;
   logic                [strap_pkg::NIBBLE_W-1:0] nibble;

   modport ctrl (output load, output word, output ratio,
                 input busy, input sclk, input nibble);
   modport shifter (input load, input word, input ratio,
                    output busy, output sclk, output nibble);
endinterface

// ### core/strap_sync.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/10ps
module strap_sync #(
   parameter int WIDTH = 1
) (
   // System.
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Data.
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] q_reg;
   logic [WIDTH-1:0] q_next;

   always_comb begin
      meta_next = d_i;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= meta_next;
         q_reg    <= q_next;
      end
   end

   assign q_o = q_reg;
endmodule

// ### core/column_shifter.sv
// Serialises a word into nibbles clocked by the column shift clock.
`timescale 1ns/10ps
module column_shifter (
   // System.
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   // Link to the decoder.
   column_link_if.shifter link
);
   typedef enum logic [1:0] {IDLE, HIGH, LOW} state_t;

   state_t                                state_reg;
   state_t                                state_next;
   logic [strap_pkg::WORD_W-1:0]          word_reg;
   logic [strap_pkg::WORD_W-1:0]          word_next;
   logic [strap_pkg::CNT_W-1:0]           cnt_reg;
   logic [strap_pkg::CNT_W-1:0]           cnt_next;
   logic [strap_pkg::CNT_W-1:0]           half_reg;
   logic [strap_pkg::CNT_W-1:0]           half_next;
   logic [strap_pkg::CNT_W-1:0]           left_reg;
   logic [strap_pkg::CNT_W-1:0]           left_next;
   logic                                  sclk_reg;
   logic                                  sclk_next;
   logic [strap_pkg::CNT_W-1:0]           hi_len_reg;
   logic [strap_pkg::CNT_W-1:0]           hi_len_next;

   always_comb begin
      state_next = state_reg;
      word_next  = word_reg;
      cnt_next   = cnt_reg;
      half_next  = half_reg;
      left_next  = left_reg;
      sclk_next  = sclk_reg;
      hi_len_next = sclk_reg ? hi_len_reg + 4'h1 : 4'h0;
      unique case (state_reg)
         IDLE: begin
            if (link.load) begin
               // The ratio is taken per word; a strap change applies to the next one.
               unique case (link.ratio)
                  strap_pkg::RATIO_4:  half_next = strap_pkg::HALF_4;  // [RQ3]
                  strap_pkg::RATIO_8:  half_next = strap_pkg::HALF_8;  // [RQ3]
                  default:             half_next = strap_pkg::HALF_16; // [RQ3]
               endcase
               word_next  = link.word;
               cnt_next   = half_next - 4'h1;
               left_next  = 4'(strap_pkg::NIBBLES - 1);
               sclk_next  = 1'b1;
               state_next = HIGH;
            end
         end
         HIGH: begin
            if (cnt_reg == 4'h0) begin
               sclk_next  = 1'b0;
               cnt_next   = half_reg - 4'h1;
               state_next = LOW;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         LOW: begin
            if (cnt_reg != 4'h0) begin
               cnt_next = cnt_reg - 4'h1;
            end else if (left_reg == 4'h0) begin
               state_next = IDLE;
            end else begin
               // New nibble goes out with the rising edge, a half period before capture.
               word_next  = word_reg >> strap_pkg::NIBBLE_W; // [RQ9]
               left_next  = left_reg - 4'h1;
               cnt_next   = half_reg - 4'h1;
               sclk_next  = 1'b1;
               state_next = HIGH;
            end
         end
         default: state_next = IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg  <= IDLE;
         word_reg   <= '0;
         cnt_reg    <= '0;
         half_reg   <= strap_pkg::HALF_4;
         left_reg   <= '0;
         sclk_reg   <= 1'b0;
         hi_len_reg <= '0;
      end else begin
         state_reg  <= state_next;
         word_reg   <= word_next;
         cnt_reg    <= cnt_next;
         half_reg   <= half_next;
         left_reg   <= left_next;
         sclk_reg   <= sclk_next;
         hi_len_reg <= hi_len_next;
      end
   end

   assign link.busy   = (state_reg != IDLE);
   assign link.sclk   = sclk_reg;
   assign link.nibble = word_reg[strap_pkg::NIBBLE_W-1:0];

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_SHIFT_HALF_PERIOD: assert property ( // [RQ3]
      $fell(sclk_reg) |-> hi_len_reg == half_reg)
      else $error("Column shift clock high time differs from half the ratio.");

   AST_NIBBLE_STABLE: assert property ( // [RQ9]
      $changed(word_reg[strap_pkg::NIBBLE_W-1:0]) |-> $rose(sclk_reg))
      else $error("Column data changed away from a shift clock rising edge.");
endmodule

// ### verification/host_strap_model.sv
// Far-side model: board straps and host address pins.
`timescale 1ns/10ps
module host_strap_model (
   // System.
   input  wire logic        clk_i,
   // Requested pin levels.
   input  wire logic [4:0]  straps_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        float_upper_i,
   // Pins.
   output logic      [4:0]  config_straps_o,
   output logic      [14:0] host_addr_upper_o,
   output logic             host_addr_lsb_o
);
   // Levels change only just after an edge and then stay firm.
   always_ff @(posedge clk_i) begin
      config_straps_o <= straps_i;
      host_addr_lsb_o <= addr_i[0];
      // Indirect mode grounds the upper pins unless a test asks otherwise.
      host_addr_upper_o <= (straps_i[4] && !float_upper_i) ? 15'h0000 : addr_i[15:1];
   end
   // One clock source only; the crystal pins are left out of this model.
endmodule

// ### verification/host_bus_config_strap_decoder_bench.sv
// Self-checking bench for the configuration strap decoder.
`timescale 1ns/10ps
module host_bus_config_strap_decoder_bench;
   typedef struct {
      logic [4:0]  s;
      logic [15:0] a;
      logic        bad;
      logic        vld;
      logic [15:0] idx;
   } row_t;
   logic                    clk_i;
   logic                    rst_i;
   logic                    wb_cyc;
   logic                    wb_stb;
   logic                    wb_we;
   logic [7:0]              wb_adr;
   logic [3:0]              wb_sel;
   logic [31:0]             wb_wdat;
   logic [31:0]             wb_rdat;
   logic                    wb_ack;
   logic [4:0]              straps;
   logic [15:0]             addr;
   logic                    float_upper;
   logic [4:0]              strap_pins;
   logic [14:0]             upper_pins;
   logic                    lsb_pin;
   logic                    ind;
   strap_pkg::bus_style_t   style;
   strap_pkg::shift_ratio_t ratio;
   logic                    vld;
   logic [15:0]             idx;
   logic                    sclk;
   logic [3:0]              nib;
   logic [31:0]             rd;
   int                      n_fail;
   int                      tests_run;
   int                      k;
   row_t rows [9] = '{'{5'h00, 16'h1235, 1'b0, 1'b1, 16'h1235},
                      '{5'h05, 16'hffff, 1'b0, 1'b0, 16'hffff},
                      '{5'h0a, 16'h8000, 1'b0, 1'b0, 16'h8000},
                      '{5'h0f, 16'h0002, 1'b0, 1'b0, 16'h0002},
                      '{5'h11, 16'h0001, 1'b0, 1'b1, 16'h0001},
                      '{5'h18, 16'h0000, 1'b0, 1'b1, 16'h0000},
                      '{5'h1e, 16'hfff3, 1'b1, 1'b1, 16'h0001},
                      '{5'h14, 16'h0001, 1'b0, 1'b0, 16'h0001},
                      '{5'h0e, 16'h7ffe, 1'b0, 1'b1, 16'h7ffe}};

   host_strap_model host_strap_model_i (
      .clk_i             (clk_i),
      .straps_i          (straps),
      .addr_i            (addr),
      .float_upper_i     (float_upper),
      .config_straps_o   (strap_pins),
      .host_addr_upper_o (upper_pins),
      .host_addr_lsb_o   (lsb_pin)
   );

   host_bus_config_strap_decoder host_bus_config_strap_decoder_i (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .wb_cyc_i              (wb_cyc),
      .wb_stb_i              (wb_stb),
      .wb_we_i               (wb_we),
      .wb_adr_i              (wb_adr),
      .wb_sel_i              (wb_sel),
      .wb_dat_i              (wb_wdat),
      .wb_dat_o              (wb_rdat),
      .wb_ack_o              (wb_ack),
      .config_straps_i       (strap_pins),
      .host_addr_upper_i     (upper_pins),
      .host_addr_lsb_i       (lsb_pin),
      .addressing_indirect_o (ind),
      .bus_style_o           (style),
      .shift_ratio_o         (ratio),
      .config_valid_o        (vld),
      .host_reg_index_o      (idx),
      .column_shift_clock_o  (sclk),
      .column_data_out_o     (nib)
   );

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // The master never assumes a latency; a wait ends on ack, or at the bound of 50 cycles.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= w;
      wb_adr  <= a;
      wb_wdat <= d;
      wb_sel  <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      check("wb ack", 32'(wb_ack), 32'h1);
   endtask

   task run_shift(input logic [31:0] w, input int half, input logic wr);
      int h;
      int n;
      int t;
      h = 0;
      n = 0;
      t = 0;
      if (wr) begin
         wb(1'b1, strap_pkg::REG_DATA, w);
      end
      while (n < 8 && t < 500) begin
         @(posedge clk_i);
         #1;
         t++;
         if (sclk === 1'b1) begin
            h++;
         end else if (h != 0) begin
            check("nibble", 32'(nib), 32'(w[4*n +: 4]));
            check("high time", 32'(h), 32'(half));
            n++;
            h = 0;
         end
      end
      check("nibble count", 32'(n), 32'h8);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      repeat (8000) @(posedge clk_i);
      n_fail++;
      $display("[FAIL] watchdog expected finish seen timeout");
      report_and_stop;
   end

   initial begin
      rst_i = 1'b1;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = 47'h0;
      {straps, addr, float_upper} = 22'h0;
      n_fail = 0;
      tests_run = 0;
      repeat (10) @(posedge clk_i);
      #1;
      check("reset outputs", 32'({wb_ack, vld, sclk, nib, idx}), 32'h0);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, strap_pkg::REG_CTRL, 32'h0);
      check("ctrl reset", rd, strap_pkg::CTRL_RESET);
      wb(1'b0, strap_pkg::REG_DATA, 32'h0);
      check("data reset", rd, strap_pkg::DATA_RESET);
      wb(1'b0, 8'h40, 32'h0);
      check("unmapped read", rd, 32'h0);
      // Straps move between rows with no reset in between.
      foreach (rows[i]) begin
         @(posedge clk_i);
         straps      <= rows[i].s;
         addr        <= rows[i].a;
         float_upper <= rows[i].bad;
         repeat (6) @(posedge clk_i);
         #1;
         check("indirect", 32'(ind), 32'(rows[i].s[4]));
         check("style", 32'(style), 32'(rows[i].s[3:2]));
         check("ratio", 32'(ratio), 32'(rows[i].s[1:0]));
         check("valid", 32'(vld), 32'(rows[i].vld));
         check("host index", 32'(idx), 32'(rows[i].idx));
         wb(1'b0, strap_pkg::REG_STATUS, 32'h0);
         check("status", 32'({rd[10:8], rd[5:0]}), 32'({rows[i].s[3:2] == 2'h2 && !rows[i].s[4],
               rows[i].s[1:0] == 2'h3, rows[i].s[3:2] == 2'h1, rows[i].vld, rows[i].s}));
         wb(1'b0, strap_pkg::REG_HOST_INDEX, 32'h0);
         check("index reg", rd, {16'h0, rows[i].idx});
      end
      float_upper <= 1'b0;
      wb(1'b1, strap_pkg::REG_CTRL, 32'h1);
      for (int r = 0; r < 3; r++) begin
         @(posedge clk_i);
         straps <= 5'h0c | 5'(r);
         repeat (6) @(posedge clk_i);
         run_shift(32'h8765_4321 + 32'(r), 2 << r, 1'b1);
      end
      // A word written under a reserved ratio must wait until the straps are fixed.
      @(posedge clk_i);
      straps <= 5'h0f;
      repeat (6) @(posedge clk_i);
      wb(1'b1, strap_pkg::REG_DATA, 32'h1e2d_3c4b);
      k = 0;
      repeat (40) begin
         @(posedge clk_i);
         #1;
         k += int'(sclk === 1'b1);
      end
      check("held clock", 32'(k), 32'h0);
      wb(1'b0, strap_pkg::REG_STATUS, 32'h0);
      check("pending", 32'(rd[7]), 32'h1);
      @(posedge clk_i);
      straps <= 5'h0c;
      run_shift(32'h1e2d_3c4b, 2, 1'b0);
      repeat (4) @(posedge clk_i);
      wb(1'b0, strap_pkg::REG_STATUS, 32'h0);
      check("idle after word", 32'(rd[7:6]), 32'h0);
      report_and_stop;
   end
endmodule
